// [core/sow_system_options.sv]
/*
 * System options and watchdog: option registers with write-once bits, the
 * watchdog with normal and windowed refresh, stop gating, pin route
 * selects, adc trigger select, divided clock output and identity.
 * Assumes the reset controller feeds reset requests back to reset_in
 * and that the 1 kHz clock and irq pin are asynchronous.
 */
// Implementation choices: the plain strobed port and the register offsets.
// Summary of operation
// - first options register write-once, always readable
// - timeout code selects period; zero disables
// - low-power clock overflows 2^5, 2^8, 2^10
// - bus clock overflows 2^13, 2^16, 2^18
// - clock select and window enable write-once
// - windowed refresh only in final quarter
// - early write in windowed mode resets
// - window opens at 6144, 49152, 196608
// - stop without enable forces illegal-opcode reset
// - serial two pins routed by bit 4
// - i2c pins routed by bit 3
// - bit 4 selects adc hardware trigger
// - nonzero divider drives bus over twice field
// - zero divider frees clock output pin
// - read-only part number registers
// - high identity holds revision, writes ignored
// - 0x55 then 0xAA restarts watchdog
// - status write other than 0x55 or 0xAA resets
`default_nettype none

module sow_system_options #(
    parameter int         BUS_COUNT_1 = sow_pkg::BUS_COUNT_1,
    parameter int         BUS_COUNT_2 = sow_pkg::BUS_COUNT_2,
    parameter int         BUS_COUNT_3 = sow_pkg::BUS_COUNT_3,
    parameter int         BUS_OPEN_1  = sow_pkg::BUS_OPEN_1,
    parameter int         BUS_OPEN_2  = sow_pkg::BUS_OPEN_2,
    parameter int         BUS_OPEN_3  = sow_pkg::BUS_OPEN_3,
    // arbitrary identity values
    parameter logic [11:0] PART_NUMBER = 12'h5A3,
    parameter logic [3:0]  REVISION    = 4'h1
) (
    // clock and reset
    input  wire logic                      sys_clk_in,
    input  wire logic                      reset_in,
    // register port
    input  wire sow_pkg::sow_bus_req_type  bus_req_in,
    output logic [7:0]                     rdata_out,
    // reset status flags kept by the reset controller
    input  wire logic [7:0]                reset_flags_in,
    // low-power clock and cpu stop request
    input  wire logic                      lpo_clk_in,
    input  wire logic                      stop_execute_in,
    // reset requests and stop entry
    output logic                           watchdog_reset_out,
    output logic                           illegal_opcode_reset_out,
    output logic                           stop_enter_out,
    // pin routing
    output logic                           serial_two_on_port_e_out,
    output logic                           i2c_on_port_e_out,
    // adc trigger
    input  wire logic                      adc_hw_trigger_enable_in,
    input  wire logic                      rtc_overflow_in,
    input  wire logic                      irq_pin_in,
    output logic                           adc_trigger_out,
    // divided clock output pin
    output logic                           port_a_pin0_out,
    output logic                           port_a_pin0_oe_out
);

    localparam int W = sow_pkg::WDOG_WIDTH;

    sow_pkg::sow_opts_one_type opts_one;
    logic [7:0]                opts_two;
    logic                      one_locked;
    logic                      two_locked;
    sow_pkg::sow_seq_type      seq;
    logic [W-1:0]              wdog_count;
    logic [2:0]                lpo_sync;
    logic [1:0]                irq_sync;
    logic [2:0]                div_count;
    logic                      clk_level;

    logic         wr_status;
    logic         wr_one;
    logic         wr_two;
    logic         clk_sel;
    logic         window_en;
    logic         wdog_on;
    logic         tick;
    logic         early;
    logic         bad_key;
    logic         refresh;
    logic         overflow;
    logic         next_wdog_reset;
    logic [2:0]   divider;
    logic [W-1:0] last_count;
    logic [W-1:0] open_count;

    // last count before overflow for a source and timeout code
    function automatic logic [W-1:0] wdog_last(input logic       bus,
                                               input logic [1:0] code);
        logic [W-1:0] r;
        r = '0;
        case (code)
            2'b01: r = bus ? W'(BUS_COUNT_1 - 1)
                           : W'(sow_pkg::LPO_COUNT_1 - 1);
            2'b10: r = bus ? W'(BUS_COUNT_2 - 1)
                           : W'(sow_pkg::LPO_COUNT_2 - 1);
            2'b11: r = bus ? W'(BUS_COUNT_3 - 1)
                           : W'(sow_pkg::LPO_COUNT_3 - 1);
            default: r = '0;
        endcase
        return r;
    endfunction

    // count at which the windowed refresh opens
    function automatic logic [W-1:0] wdog_open(input logic [1:0] code);
        logic [W-1:0] r;
        r = '0;
        case (code)
            2'b01:   r = W'(BUS_OPEN_1);
            2'b10:   r = W'(BUS_OPEN_2);
            2'b11:   r = W'(BUS_OPEN_3);
            default: r = '0;
        endcase
        return r;
    endfunction

    // bus decode
    assign wr_status = bus_req_in.wr &&
                       bus_req_in.addr == sow_pkg::ADDR_RESET_STATUS;
    assign wr_one    = bus_req_in.wr &&
                       bus_req_in.addr == sow_pkg::ADDR_OPTS_ONE;
    assign wr_two    = bus_req_in.wr &&
                       bus_req_in.addr == sow_pkg::ADDR_OPTS_TWO;

    assign clk_sel   = opts_two[sow_pkg::TWO_CLK_SEL_BIT];
    assign window_en = opts_two[sow_pkg::TWO_WINDOW_BIT];
    assign divider   = opts_two[sow_pkg::TWO_DIV_MSB:0];

    // first options register, locked by its first write
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            opts_one   <= sow_pkg::OPTS_ONE_RESET;
            one_locked <= 1'b0;
        end else if (wr_one && !one_locked) begin
            opts_one        <= bus_req_in.wdata;
            opts_one.unused <= 3'h0;
            one_locked      <= 1'b1;
        end
    end

    // second options register: bits 7:6 lock, bits 4 and 2:0 stay writable, bits 5 and 3 stay zero
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            opts_two   <= sow_pkg::OPTS_TWO_RESET;
            two_locked <= 1'b0;
        end else if (wr_two) begin
            opts_two <= (bus_req_in.wdata & sow_pkg::OPTS_TWO_RW_MASK)
                      | (opts_two & ~sow_pkg::OPTS_TWO_RW_MASK);
            if (!two_locked) begin
                opts_two[7:6] <= bus_req_in.wdata[7:6];
                two_locked    <= 1'b1;
            end
        end
    end

    // register reads, data one cycle later
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                sow_pkg::ADDR_RESET_STATUS: rdata_out <= reset_flags_in;
                sow_pkg::ADDR_OPTS_ONE:     rdata_out <= opts_one;
                sow_pkg::ADDR_OPTS_TWO:
                    rdata_out <= opts_two & 8'hD7;
                sow_pkg::ADDR_IDENT_HIGH:
                    rdata_out <= {REVISION, PART_NUMBER[11:8]};
                sow_pkg::ADDR_IDENT_LOW:
                    rdata_out <= PART_NUMBER[7:0];
                default:                    rdata_out <= 8'h00;
            endcase
        end
    end

    // synchronisers for the low-power clock and irq pin
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            lpo_sync <= 3'h0;
            irq_sync <= 2'h0;
        end else begin
            lpo_sync <= {lpo_sync[1:0], lpo_clk_in};
            irq_sync <= {irq_sync[0], irq_pin_in};
        end
    end

    // watchdog decode
    assign wdog_on    = opts_one.timeout != 2'b00;
    assign last_count = wdog_last(clk_sel, opts_one.timeout);
    assign open_count = wdog_open(opts_one.timeout);
    assign tick       = clk_sel ? 1'b1 : (lpo_sync[1] && !lpo_sync[2]);
    // windowed mode only applies to the bus clock source
    assign early      = window_en && clk_sel &&
                        wdog_count < open_count;
    assign bad_key    = bus_req_in.wdata != sow_pkg::KEY_FIRST &&
                        bus_req_in.wdata != sow_pkg::KEY_SECOND;
    assign refresh    = wr_status && seq == sow_pkg::SEQ_ARMED &&
                        bus_req_in.wdata == sow_pkg::KEY_SECOND &&
                        !early;
    assign overflow   = tick && wdog_count >= last_count;

    always_comb begin
        next_wdog_reset = 1'b0;
        if (wdog_on) begin
            if (wr_status && (bad_key || early)) begin
                next_wdog_reset = 1'b1;
            end
            if (overflow) begin
                next_wdog_reset = 1'b1;
            end
        end
    end

    // refresh key sequencer
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            seq <= sow_pkg::SEQ_IDLE;
        end else if (wr_status) begin
            case (seq)
                sow_pkg::SEQ_IDLE:
                    seq <= (bus_req_in.wdata == sow_pkg::KEY_FIRST)
                         ? sow_pkg::SEQ_ARMED : sow_pkg::SEQ_IDLE;
                sow_pkg::SEQ_ARMED:
                    seq <= (bus_req_in.wdata == sow_pkg::KEY_FIRST)
                         ? sow_pkg::SEQ_ARMED : sow_pkg::SEQ_IDLE;
                default: seq <= sow_pkg::SEQ_IDLE;
            endcase
        end
    end

    // watchdog counter
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wdog_count <= '0;
        end else if (!wdog_on || refresh || overflow) begin
            wdog_count <= '0;
        end else if (tick) begin
            wdog_count <= wdog_count + W'(1);
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            watchdog_reset_out <= 1'b0;
        end else begin
            watchdog_reset_out <= next_wdog_reset;
        end
    end

    // stop gating
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            illegal_opcode_reset_out <= 1'b0;
            stop_enter_out           <= 1'b0;
        end else begin
            illegal_opcode_reset_out <= stop_execute_in &&
                                        !opts_one.stop_en;
            stop_enter_out           <= stop_execute_in &&
                                        opts_one.stop_en;
        end
    end

    // pin routes and adc trigger
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            serial_two_on_port_e_out <= 1'b0;
            i2c_on_port_e_out        <= 1'b0;
            adc_trigger_out          <= 1'b0;
        end else begin
            serial_two_on_port_e_out <= opts_one.serial_sel;
            i2c_on_port_e_out        <= opts_one.i2c_sel;
            adc_trigger_out <= adc_hw_trigger_enable_in &&
                (opts_two[sow_pkg::TWO_ADC_SEL_BIT] ? irq_sync[1]
                                                   : rtc_overflow_in);
        end
    end

    // divided clock output: toggles every divider cycles
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_count <= 3'h0;
            clk_level <= 1'b0;
        end else if (divider == 3'h0) begin
            div_count <= 3'h0;
            clk_level <= 1'b0;
        end else if (div_count >= divider - 3'h1) begin
            div_count <= 3'h0;
            clk_level <= !clk_level;
        end else begin
            div_count <= div_count + 3'h1;
        end
    end

    assign port_a_pin0_out    = clk_level;
    assign port_a_pin0_oe_out = divider != 3'h0;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    AST_ONE_LOCK: assert property (
        one_locked && wr_one |=> $stable(opts_one))
        else $error("locked options one changed");

    AST_TWO_LOCK: assert property (
        two_locked && wr_two |=> $stable(opts_two[7:6]))
        else $error("locked watchdog selects changed");

    AST_WDOG_OFF: assert property (
        !wdog_on && !$past(wdog_on) |-> !watchdog_reset_out)
        else $error("disabled watchdog reset");

    AST_BAD_KEY: assert property (
        wdog_on && wr_status && bad_key |=> watchdog_reset_out)
        else $error("bad key did not reset");

    AST_EARLY: assert property (
        wdog_on && wr_status && window_en && clk_sel &&
        wdog_count < open_count |=> watchdog_reset_out)
        else $error("early windowed write did not reset");

    AST_REFRESH: assert property (
        wdog_on && refresh && !overflow
        |=> wdog_count == '0 && !watchdog_reset_out)
        else $error("refresh did not restart counter");

    AST_OVERFLOW: assert property (
        wdog_on && tick && wdog_count == last_count
        |=> watchdog_reset_out ##0 wdog_count == '0)
        else $error("overflow did not reset");

    AST_STOP: assert property (
        stop_execute_in |=> illegal_opcode_reset_out != stop_enter_out)
        else $error("stop gating wrong");

    AST_CLK_OFF: assert property (
        divider == 3'h0 |=> !port_a_pin0_out)
        else $error("clock pin driven while off");

    AST_IDENT: assert property (
        bus_req_in.rd && bus_req_in.addr == sow_pkg::ADDR_IDENT_LOW
        |=> rdata_out == PART_NUMBER[7:0])
        else $error("identity low read wrong");

    AST_ADC_RTC: assert property (
        adc_hw_trigger_enable_in && !opts_two[sow_pkg::TWO_ADC_SEL_BIT] &&
        rtc_overflow_in |=> adc_trigger_out)
        else $error("rtc trigger not passed");

    AST_LPO_NO_WINDOW: assert property (
        wdog_on && wr_status && !clk_sel && !bad_key && !overflow
        |=> !watchdog_reset_out)
        else $error("window applied to slow clock");

    COV_REFRESH: cover property (refresh);
    COV_OVERFLOW: cover property (wdog_on && overflow);
    COV_LOCKED_WRITE: cover property (one_locked && wr_one);
    COV_CLK_TOGGLE: cover property (port_a_pin0_oe_out &&
                                    $rose(port_a_pin0_out));

endmodule

`default_nettype wire

// [include/sow_pkg.sv]
/*
 * Package for the system options and watchdog configuration block:
 * register indices, field positions, reset values, timing figures,
 * the bus request carrier and the refresh sequencer states.
 * Assumes a single 25 MHz bus clock domain.
 */
`default_nettype none

package sow_pkg;

    // register indices on the plain register port
    localparam logic [3:0] ADDR_RESET_STATUS = 4'h0;
    localparam logic [3:0] ADDR_OPTS_ONE     = 4'h1;
    localparam logic [3:0] ADDR_OPTS_TWO     = 4'h2;
    localparam logic [3:0] ADDR_IDENT_HIGH   = 4'h3;
    localparam logic [3:0] ADDR_IDENT_LOW    = 4'h4;

    // reset values
    localparam logic [7:0] OPTS_ONE_RESET = 8'hC0;
    localparam logic [7:0] OPTS_TWO_RESET = 8'h00;

    // field positions of the second options register
    localparam int TWO_CLK_SEL_BIT = 7;
    localparam int TWO_WINDOW_BIT  = 6;
    localparam int TWO_ADC_SEL_BIT = 4;
    localparam int TWO_DIV_MSB     = 2;

    // writable bits of the second options register
    localparam logic [7:0] OPTS_TWO_RW_MASK = 8'h17;

    // refresh key values
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // low-power clock overflow counts, codes 01, 10, 11
    localparam int LPO_COUNT_1 = 32;
    localparam int LPO_COUNT_2 = 256;
    localparam int LPO_COUNT_3 = 1024;

    // bus clock overflow and window-open counts
    localparam int BUS_COUNT_1 = 8192;
    localparam int BUS_COUNT_2 = 65536;
    localparam int BUS_COUNT_3 = 262144;
    localparam int BUS_OPEN_1  = 6144;
    localparam int BUS_OPEN_2  = 49152;
    localparam int BUS_OPEN_3  = 196608;

    // watchdog counter width
    localparam int WDOG_WIDTH = 19;

    typedef struct packed {
        logic [1:0] timeout;
        logic       stop_en;
        logic       serial_sel;
        logic       i2c_sel;
        logic [2:0] unused;
    } sow_opts_one_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sow_bus_req_type;

    typedef enum logic [0:0] {
        SEQ_IDLE  = 1'b0,
        SEQ_ARMED = 1'b1
    } sow_seq_type;

endpackage

`default_nettype wire

// [tb/tb_top.sv]
/*
 * Self-checking bench for the system options and watchdog block.
 * Assumes the bench itself plays the reset controller: each scenario
 * restarts the block with a fresh reset after a watchdog pulse.
 */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int          CNT1 = 64;
    localparam int          CNT2 = 128;
    localparam int          CNT3 = 256;
    localparam int          OPEN1 = 48;
    // arbitrary identity values
    localparam logic [11:0] PART = 12'h5A3;
    localparam logic [3:0]  REV  = 4'h2;

    logic                     sys_clk = 1'b0;
    logic                     reset_in = 1'b1;
    sow_pkg::sow_bus_req_type bus_req = '0;
    logic [7:0]               rdata;
    logic                     lpo_clk = 1'b0;
    logic                     lpo_run = 1'b0;
    logic                     stop_exec = 1'b0;
    logic                     adc_en = 1'b0;
    logic                     rtc_ovf = 1'b0;
    logic                     irq = 1'b0;
    logic                     wdog_rst;
    logic                     ill_rst;
    logic                     stop_ent;
    logic                     ser_e;
    logic                     i2c_e;
    logic                     adc_trig;
    logic                     clk_pin;
    logic                     clk_oe;
    int                       err_total = 0;
    int                       comparisons = 0;

    sow_system_options #(
        .BUS_COUNT_1 (CNT1),
        .BUS_COUNT_2 (CNT2),
        .BUS_COUNT_3 (CNT3),
        .BUS_OPEN_1  (OPEN1),
        .BUS_OPEN_2  (96),
        .BUS_OPEN_3  (192),
        .PART_NUMBER (PART),
        .REVISION    (REV)
    ) i_dut (
        .sys_clk_in               (sys_clk),
        .reset_in                 (reset_in),
        .bus_req_in               (bus_req),
        .rdata_out                (rdata),
        .reset_flags_in           (8'h82),
        .lpo_clk_in               (lpo_clk),
        .stop_execute_in          (stop_exec),
        .watchdog_reset_out       (wdog_rst),
        .illegal_opcode_reset_out (ill_rst),
        .stop_enter_out           (stop_ent),
        .serial_two_on_port_e_out (ser_e),
        .i2c_on_port_e_out        (i2c_e),
        .adc_hw_trigger_enable_in (adc_en),
        .rtc_overflow_in          (rtc_ovf),
        .irq_pin_in               (irq),
        .adc_trigger_out          (adc_trig),
        .port_a_pin0_out          (clk_pin),
        .port_a_pin0_oe_out       (clk_oe)
    );

    always #20 sys_clk = ~sys_clk;
    // slow clock: changes on falling bus edges, rests low when stopped
    always #200 lpo_clk = lpo_run ? ~lpo_clk : 1'b0;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: %s seen %h expected %h", $time, msg,
                     seen, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        reset_in <= 1'b1;
        repeat (10) @(posedge sys_clk);
        reset_in <= 1'b0;
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic read_chk(input logic [3:0] a, input logic [7:0] exp,
                            input string msg);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        // data stand from the cycle after the strobe until the next read
        #1;
        chk(32'(rdata), 32'(exp), msg);
    endtask

    // cycles until a watchdog reset pulse, lim if none
    task automatic wait_wdog(input int lim, output int n);
        n = 0;
        #1;
        while (n < lim && wdog_rst !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    task automatic t_regs();
        int n;
        do_reset();
        read_chk(4'h1, 8'hC0, "opts one reset");
        read_chk(4'h2, 8'h00, "opts two reset");
        bus_write(4'h3, 8'hFF);
        bus_write(4'h4, 8'h00);
        read_chk(4'h3, {REV, PART[11:8]}, "ident high");
        read_chk(4'h4, PART[7:0], "ident low");
        read_chk(4'h9, 8'h00, "unmapped read");
        read_chk(4'h0, 8'h82, "status read");
        bus_write(4'h1, 8'h78);
        bus_write(4'h1, 8'h00);
        read_chk(4'h1, 8'h78, "opts one lock");
        chk(32'(ser_e), 32'h1, "serial on port e");
        chk(32'(i2c_e), 32'h1, "i2c on port e");
        @(posedge sys_clk);
        stop_exec <= 1'b1;
        @(posedge sys_clk);
        stop_exec <= 1'b0;
        #1;
        chk(32'({stop_ent, ill_rst}), 32'h2, "stop enabled");
        do_reset();
        chk(32'({ser_e, i2c_e}), 32'h0, "pins on port f");
        @(posedge sys_clk);
        stop_exec <= 1'b1;
        @(posedge sys_clk);
        stop_exec <= 1'b0;
        #1;
        chk(32'({stop_ent, ill_rst}), 32'h1, "stop disabled");
    endtask

    task automatic t_wdog();
        int n;
        int exp_n;
        do_reset();
        bus_write(4'h1, 8'h00);
        bus_write(4'h2, 8'h80);
        bus_write(4'h0, 8'h12);
        wait_wdog(100, n);
        chk(32'(n), 32'd100, "disabled watchdog");
        do_reset();
        bus_write(4'h1, 8'h40);
        bus_write(4'h2, 8'h80);
        wait_wdog(200, n);
        chk(32'(n >= CNT1 - 4 && n <= CNT1 + 2), 32'h1, "bus overflow");
        for (int c = 2; c <= 3; c++) begin
            exp_n = (c == 2) ? CNT2 : CNT3;
            do_reset();
            bus_write(4'h1, 8'(c << 6));
            bus_write(4'h2, 8'h80);
            wait_wdog(300, n);
            chk(32'(n >= exp_n - 4 && n <= exp_n + 2), 32'h1,
                "bus overflow long");
        end
        do_reset();
        bus_write(4'h1, 8'h40);
        bus_write(4'h2, 8'h80);
        repeat (40) @(posedge sys_clk);
        bus_write(4'h0, 8'h55);
        bus_write(4'h0, 8'hAA);
        wait_wdog(200, n);
        chk(32'(n >= CNT1 - 4 && n <= CNT1 + 2), 32'h1, "refresh");
        read_chk(4'h0, 8'h82, "status kept");
        do_reset();
        bus_write(4'h1, 8'h40);
        bus_write(4'h0, 8'h12);
        wait_wdog(3, n);
        chk(32'(wdog_rst), 32'h1, "bad key");
        do_reset();
        bus_write(4'h1, 8'h40);
        bus_write(4'h2, 8'h40);
        bus_write(4'h0, 8'h55);
        bus_write(4'h0, 8'hAA);
        lpo_run = 1'b1;
        wait_wdog(500, n);
        lpo_run = 1'b0;
        chk(32'(n >= 300 && n <= 340), 32'h1, "slow clock overflow");
    endtask

    task automatic t_window();
        int n;
        do_reset();
        bus_write(4'h1, 8'h40);
        bus_write(4'h2, 8'hC0);
        bus_write(4'h0, 8'h55);
        wait_wdog(3, n);
        chk(32'(wdog_rst), 32'h1, "early window write");
        do_reset();
        bus_write(4'h1, 8'h40);
        bus_write(4'h2, 8'hC0);
        bus_write(4'h2, 8'h00);
        read_chk(4'h2, 8'hC0, "opts two lock");
        repeat (44) @(posedge sys_clk);
        bus_write(4'h0, 8'h55);
        bus_write(4'h0, 8'hAA);
        wait_wdog(200, n);
        chk(32'(n >= CNT1 - 4 && n <= CNT1 + 2), 32'h1, "window refresh");
    endtask

    task automatic t_adc_clk();
        int n;
        logic lvl;
        do_reset();
        adc_en <= 1'b1;
        bus_write(4'h2, 8'h10);
        irq <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(32'(adc_trig), 32'h1, "irq trigger");
        bus_write(4'h2, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(32'(adc_trig), 32'h0, "irq ignored");
        @(posedge sys_clk);
        rtc_ovf <= 1'b1;
        @(posedge sys_clk);
        rtc_ovf <= 1'b0;
        #1;
        chk(32'(adc_trig), 32'h1, "rtc trigger");
        bus_write(4'h2, 8'h03);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(32'(clk_oe), 32'h1, "clock out enabled");
        n = 0;
        @(clk_pin);
        lvl = clk_pin;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (n < 20 && clk_pin === lvl);
        chk(32'(n), 32'd3, "half period of three");
        bus_write(4'h2, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(32'({clk_oe, clk_pin}), 32'h0, "clock out off");
    endtask

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        do_reset();
        t_regs();
        t_wdog();
        t_window();
        t_adc_clk();
        give_verdict();
    end

    initial begin
        #400000;
        err_total++;
        give_verdict();
    end

endmodule

`default_nettype wire
